// file: src/jtx_lane_ctrl.sv
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`default_nettype none

module jtx_lane_ctrl #(
   parameter int LANES = 8,
   parameter logic [31:0] FOUR_LANE_FMTS = 32'h0000_00FE
) (
   // Clock, reset and clock enable
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // Power-down pin
   input wire logic i_shutdown_input,
   // Link status and sample data, same clock
   input wire logic i_ila_done,
   input wire logic i_serdes_init_done,
   input wire logic [71:0] i_samp_a,
   input wire logic [71:0] i_samp_b,
   input wire logic [63:0] i_link_octets,
   // Lane outputs
   output logic [63:0] o_lane_data,
   output logic [7:0] o_lane_en,
   output logic o_link_encode,
   output logic o_fec_en
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] rdata;
      logic wr_pend;
      logic [7:0] waddr;
      logic ramp_run;
      logic [7:0] ramp;
      logic [2:0] oct;
      logic clk_ph;
      logic [71:0] fa;
      logic [71:0] fb;
      logic [63:0] lane;
      logic [7:0] en;
      logic enc;
      logic fec;
   } jtx_top_st_t;

   jtx_top_st_t st_q;
   jtx_top_st_t st_d;

   // ------------------------------------------------------------------
   // Control decode
   // ------------------------------------------------------------------
   logic pin_pd;
   logic pd_act;
   logic [4:0] fmt;
   logic [3:0] tp;
   logic alt;
   logic four;
   logic [2:0] oct_last;
   logic [3:0] prbs_mode;
   logic [63:0] logical;
   logic [63:0] prbs_oct;
   logic addr_ok;

   jtx_sync3 u_pd_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_async(i_shutdown_input),
      .o_level(pin_pd)
   );

   assign fmt = st_q.ctrl[jtx_pkg::CTRL_FMT_LSB +: 5];
   assign tp = st_q.ctrl[jtx_pkg::CTRL_TP_LSB +: 4];
   assign alt = st_q.ctrl[jtx_pkg::CTRL_ALT_BIT];
   assign pd_act = pin_pd | st_q.ctrl[jtx_pkg::CTRL_PD_BIT];
   assign four = FOUR_LANE_FMTS[fmt];
   assign oct_last = (fmt == jtx_pkg::FMT_NINE_BIT) ? jtx_pkg::OCT_LAST_NINE
                                                   : jtx_pkg::OCT_LAST_DEF;
   assign prbs_mode = (tp >= jtx_pkg::TP_PRBS7 && tp <= jtx_pkg::TP_PRBS31) ? tp
                                                                          : jtx_pkg::TP_OFF;
   assign addr_ok = (i_haddr[31:8] == 24'h00_0000);

   // ------------------------------------------------------------------
   // Per-lane pattern sources
   // ------------------------------------------------------------------
   for (genvar k = 0; k < LANES; k++) begin : g_lane
      logic [63:0] short_frame;
      logic [23:0] nine_frame;
      logic [8:0] s_lo;
      logic [8:0] s_hi;

      // Each lane starts from its own seed so no two lanes share a phase.
      jtx_prbs_lane #(
         .SEED(31'h7FFF_FF00 | 31'(k + 1))
      ) u_prbs (
         .i_clk(i_clk),
         .i_rst_n(i_rst_n),
         .i_ce(i_ce && !pd_act),
         .i_mode(prbs_mode),
         .o_octet(prbs_oct[8 * k +: 8])
      );

      always_comb begin
         short_frame = '0;
         for (int w = 0; w < 5; w++) begin
            short_frame[63 - 12 * w -: 12] = {jtx_pkg::SHORT_HI_BASE - 4'(k), 4'(k),
                                              4'(w + 1)};
         end
         if (k < 4) begin
            s_lo = st_q.fa[9 * k +: 9];
            s_hi = st_q.fa[9 * (k + 4) +: 9];
         end else begin
            s_lo = st_q.fb[9 * (k - 4) +: 9];
            s_hi = st_q.fb[9 * k +: 9];
         end
         nine_frame = {s_lo, 3'b000, s_hi, 3'b000};
         case (tp)
            jtx_pkg::TP_PRBS7, jtx_pkg::TP_PRBS9, jtx_pkg::TP_PRBS15,
            jtx_pkg::TP_PRBS23, jtx_pkg::TP_PRBS31: begin
               logical[8 * k +: 8] = prbs_oct[8 * k +: 8];
            end
            jtx_pkg::TP_CLOCK: begin
               logical[8 * k +: 8] = st_q.clk_ph ? jtx_pkg::CLK_ZEROS
                                                 : jtx_pkg::CLK_ONES;
            end
            jtx_pkg::TP_RAMP: begin
               logical[8 * k +: 8] = st_q.ramp_run ? st_q.ramp : 8'h00;
            end
            jtx_pkg::TP_SHORT: begin
               logical[8 * k +: 8] = short_frame[63 - 8 * st_q.oct -: 8];
            end
            default: begin
               // Long transport codes fall here and send normal data.
               if (fmt == jtx_pkg::FMT_NINE_BIT) begin
                  logical[8 * k +: 8] = nine_frame[23 - 8 * st_q.oct -: 8];
               end else begin
                  logical[8 * k +: 8] = i_link_octets[8 * k +: 8];
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // Bus: a write lands in its data phase; reads are fetched at address phase.
      if (st_q.wr_pend && st_q.waddr == jtx_pkg::ADDR_CTRL) begin
         st_d.ctrl = i_hwdata;
      end
      st_d.wr_pend = 1'b0;
      if (i_hsel && i_htrans[1] && i_hready) begin
         st_d.rdata = 32'h0000_0000;
         if (i_hwrite) begin
            st_d.wr_pend = addr_ok;
            st_d.waddr = i_haddr[7:0];
         end else if (addr_ok && i_haddr[7:0] == jtx_pkg::ADDR_CTRL) begin
            st_d.rdata = st_d.ctrl;
         end else if (addr_ok && i_haddr[7:0] == jtx_pkg::ADDR_STAT) begin
            st_d.rdata = {20'h0_0000, st_q.ramp_run, pin_pd, pd_act, st_q.fec, st_q.en};
         end
      end

      // Frame octet counter and clock pattern phase.
      if (pd_act || st_q.oct >= oct_last) begin
         st_d.oct = 3'h0;
      end else begin
         st_d.oct = st_q.oct + 3'h1;
      end
      st_d.clk_ph = pd_act ? 1'b0 : ~st_q.clk_ph;
      if (st_q.oct == oct_last) begin
         st_d.fa = i_samp_a;
         st_d.fb = i_samp_b;
      end

      // Ramp waits for ILA in 8B/10B, for serializer init in 64B/66B.
      if (pd_act || tp != jtx_pkg::TP_RAMP) begin
         st_d.ramp_run = 1'b0;
         st_d.ramp = jtx_pkg::RAMP_START;
      end else if (!st_q.ramp_run) begin
         st_d.ramp_run = st_q.ctrl[jtx_pkg::CTRL_ENC66_BIT] ? i_serdes_init_done
                                                            : i_ila_done;
      end else begin
         st_d.ramp = st_q.ramp + 8'h01;
      end

      // Lane steering: four-lane formats use one half, chosen by alt.
      if (pd_act) begin
         st_d.en = 8'h00;
         st_d.lane = '0;
      end else if (four && alt) begin
         st_d.en = 8'hF0;
         st_d.lane = {logical[31:0], 32'h0000_0000};
      end else if (four) begin
         st_d.en = 8'h0F;
         st_d.lane = {32'h0000_0000, logical[31:0]};
      end else begin
         st_d.en = 8'hFF;
         st_d.lane = logical;
      end
      // PRBS and clock bypass the link layer; ramp and data are encoded.
      st_d.enc = !(prbs_mode != jtx_pkg::TP_OFF || tp == jtx_pkg::TP_CLOCK);
      // A single bit: CRC-12 when clear, FEC when set; CRC-3 has no code.
      st_d.fec = st_q.ctrl[jtx_pkg::CTRL_FEC_BIT];
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q <= '0;
         st_q.ctrl <= jtx_pkg::CTRL_RESET;
      end else if (i_ce) begin
         st_q <= st_d;
      end
   end

   // The hready output is a constant flop: the slave never inserts wait states.
   logic ready_q;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ready_q <= 1'b1;
      end else begin
         ready_q <= 1'b1;
      end
   end

   assign o_hrdata = st_q.rdata;
   assign o_hreadyout = ready_q;
   assign o_hresp = 1'b0 & ready_q;
   assign o_lane_data = st_q.lane;
   assign o_lane_en = st_q.en;
   assign o_link_encode = st_q.enc;
   assign o_fec_en = st_q.fec;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   chk_pd_drivers_off : assert property ((i_ce && pd_act) |=> o_lane_en == 8'h00)
      else $error("Lane drivers enabled during power-down.");

   chk_alt_one_set : assert property ((i_ce && four && !pd_act)
      |=> (o_lane_en == 8'h0F || o_lane_en == 8'hF0))
      else $error("Both lane sets active in a four-lane format.");

   chk_alt_upper : assert property ((i_ce && four && alt && !pd_act)
      |=> (o_lane_en == 8'hF0 && o_lane_data[31:0] == 32'h0000_0000))
      else $error("Alternate select did not move data to upper lanes.");

   chk_ramp_step : assert property ((i_ce && !pd_act && four == 1'b0
      && tp == jtx_pkg::TP_RAMP && st_q.ramp_run) ##1 (i_ce && !pd_act && st_q.ramp_run)
      |=> o_lane_data[7:0] == $past(o_lane_data[7:0]) + 8'h01)
      else $error("Ramp octet did not advance by one.");

   chk_ramp_same : assert property ((i_ce && !pd_act && !four && tp == jtx_pkg::TP_RAMP)
      |=> (o_lane_data[63:32] == o_lane_data[31:0] && o_link_encode))
      else $error("Ramp lanes differ or link layer bypassed.");

   // In four-lane formats lanes 0 and 4 together hold logical lane 0, whichever half is driven.
   chk_clk_pattern : assert property ((i_ce && !pd_act && tp == jtx_pkg::TP_CLOCK)
      ##1 (i_ce && !pd_act) |=> ((o_lane_data[7:0] | o_lane_data[39:32])
      == ~$past(o_lane_data[7:0] | o_lane_data[39:32]) && !o_link_encode))
      else $error("Clock pattern did not alternate ones and zeros.");

   chk_short_tail : assert property ((i_ce && !pd_act && !four
      && tp == jtx_pkg::TP_SHORT && fmt == jtx_pkg::FMT_ZERO && st_q.oct == 3'h7)
      |=> (o_lane_data[3:0] == 4'h0 && o_lane_data[63:60] == 4'h5))
      else $error("Short pattern tail octet wrong.");

   chk_cfg_kept : assert property ((i_ce && pd_act && !st_q.wr_pend)
      |=> $stable(st_q.ctrl))
      else $error("Configuration changed during power-down.");

   chk_fec_follow : assert property ((i_ce && !st_q.wr_pend) ##1 i_ce
      |=> o_fec_en == $past(st_q.ctrl[jtx_pkg::CTRL_FEC_BIT], 2))
      else $error("Sync header FEC select not followed.");
endmodule : jtx_lane_ctrl

`default_nettype wire

// file: src/jtx_pkg.sv
`default_nettype none

package jtx_pkg;
   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam int CTRL_FMT_LSB = 0;
   localparam int CTRL_TP_LSB = 8;
   localparam int CTRL_ALT_BIT = 12;
   localparam int CTRL_FEC_BIT = 13;
   localparam int CTRL_PD_BIT = 14;
   localparam int CTRL_ENC66_BIT = 15;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Test pattern codes
   // ------------------------------------------------------------------
   localparam logic [3:0] TP_OFF = 4'h0;
   localparam logic [3:0] TP_PRBS7 = 4'h1;
   localparam logic [3:0] TP_PRBS9 = 4'h2;
   localparam logic [3:0] TP_PRBS15 = 4'h3;
   localparam logic [3:0] TP_PRBS23 = 4'h4;
   localparam logic [3:0] TP_PRBS31 = 4'h5;
   localparam logic [3:0] TP_CLOCK = 4'h6;
   localparam logic [3:0] TP_RAMP = 4'h7;
   localparam logic [3:0] TP_SHORT = 4'h8;

   // ------------------------------------------------------------------
   // Link formats and frame lengths
   // ------------------------------------------------------------------
   localparam logic [4:0] FMT_ZERO = 5'h00;
   localparam logic [4:0] FMT_NINE_BIT = 5'h0F;
   localparam logic [2:0] OCT_LAST_DEF = 3'h7;
   localparam logic [2:0] OCT_LAST_NINE = 3'h2;
   localparam logic [7:0] RAMP_START = 8'h00;
   localparam logic [7:0] CLK_ONES = 8'hFF;
   localparam logic [7:0] CLK_ZEROS = 8'h00;
   localparam logic [3:0] SHORT_HI_BASE = 4'hF;
endpackage : jtx_pkg

`default_nettype wire

// file: src/jtx_prbs_lane.sv
`default_nettype none

module jtx_prbs_lane #(
   parameter logic [30:0] SEED = 31'h7FFF_FF01
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Pattern select and serial octet out, first bit in bit 7
   input wire logic [3:0] i_mode,
   output logic [7:0] o_octet
);
   typedef struct packed {
      logic [3:0] mode;
      logic [30:0] s;
      logic [7:0] oct;
   } jtx_prbs_st_t;

   jtx_prbs_st_t st_q;
   jtx_prbs_st_t st_d;
   logic nb;

   // Bit 0 of the history holds the newest bit, so tap n-k is s[k-1].
   always_comb begin
      st_d = st_q;
      nb = 1'b0;
      st_d.mode = i_mode;
      if (i_mode != st_q.mode) begin
         st_d.s = SEED;
      end else begin
         for (int i = 0; i < 8; i++) begin
            case (i_mode)
               jtx_pkg::TP_PRBS7: nb = st_d.s[5] ^ st_d.s[6];
               jtx_pkg::TP_PRBS9: nb = st_d.s[4] ^ st_d.s[8];
               jtx_pkg::TP_PRBS15: nb = st_d.s[13] ^ st_d.s[14];
               jtx_pkg::TP_PRBS23: nb = st_d.s[17] ^ st_d.s[22];
               jtx_pkg::TP_PRBS31: nb = st_d.s[27] ^ st_d.s[30];
               default: nb = 1'b0;
            endcase
            st_d.s = {st_d.s[29:0], nb};
            st_d.oct[7 - i] = nb;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q <= '0;
      end else if (i_ce) begin
         st_q <= st_d;
      end
   end

   assign o_octet = st_q.oct;

   chk_prbs7_recur : assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_mode == jtx_pkg::TP_PRBS7 && st_q.mode == jtx_pkg::TP_PRBS7)
      |=> (st_q.s[0] == (st_q.s[6] ^ st_q.s[7])))
      else $error("PRBS7 bit is not the XOR of bits six and seven back.");
endmodule : jtx_prbs_lane

`default_nettype wire

// file: src/jtx_sync3.sv
`default_nettype none

module jtx_sync3 (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Asynchronous level in, filtered level out
   input wire logic i_async,
   output logic o_level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } jtx_sync_st_t;

   jtx_sync_st_t st_q;
   jtx_sync_st_t st_d;

   // A change counts only once the second and third stages agree.
   always_comb begin
      st_d = st_q;
      st_d.s1 = i_async;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (st_q.s2 == st_q.s3) begin
         st_d.lvl = st_q.s3;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_q <= '0;
      end else if (i_ce) begin
         st_q <= st_d;
      end
   end

   assign o_level = st_q.lvl;
endmodule : jtx_sync3

`default_nettype wire

// file: verification/jtx_rx_model.sv
`default_nettype none

module jtx_rx_model (
   // Clock and checking control
   input wire logic i_clk,
   input wire logic i_run,
   input wire logic [3:0] i_mode,
   // Lanes from the transmitter
   input wire logic [63:0] i_lane_data,
   input wire logic [7:0] i_lane_en,
   // Running error tally
   output logic [15:0] o_err
);
   timeunit 1ns;
   timeprecision 1ps;
   int tap_a [6] = '{0, 6, 5, 14, 18, 28};
   int tap_b [6] = '{0, 7, 9, 15, 23, 31};
   logic [31:0] hist [8];
   logic [7:0] oct;
   int seen = 0;
   int errs = 0;
   // The receiver self-aligns, so the tap relation is judged, and the phase only in that lanes 0 and 1 must differ.
   always @(posedge i_clk) begin
      if (!i_run || i_lane_en == 8'h00) begin
         seen = 0;
      end else begin
         for (int k = 0; k < 8; k++) begin
            oct = i_lane_data[8*k +: 8];
            if (!i_lane_en[k]) continue;
            if (i_mode == 4'h6) begin
               if (seen > 0 && (oct != ~hist[k][7:0] || (oct != 8'hFF && oct != 8'h00)))
                  errs++;
               hist[k][7:0] = oct;
            end else begin
               for (int i = 7; i >= 0; i--) begin
                  // The first octet after a mode switch is left over from before.
                  if (seen >= 40 && oct[i] !== (hist[k][tap_a[i_mode] - 1]
                        ^ hist[k][tap_b[i_mode] - 1])) errs++;
                  hist[k] = {hist[k][30:0], oct[i]};
               end
            end
         end
         if (seen == 56 && i_mode != 4'h6 && hist[0] == hist[1]) errs++;
         seen = seen + 8;
      end
      o_err <= errs[15:0];
   end
endmodule : jtx_rx_model

`default_nettype wire

// file: verification/jtx_tb.sv
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      int due;
      logic [89:0] e;
      logic [89:0] m;
   } jtx_note_t;
   // Observed word: model errors, lane octets, lane enables, encode, fec.
   localparam logic [89:0] M_EN = {80'h0, 8'hFF, 2'h0};
   localparam logic [89:0] M_MC = 90'h3;
   localparam logic [89:0] M_DAT = {16'h0, 64'hFFFF_FFFF_FFFF_FFFF, 10'h0};
   localparam logic [89:0] M_ERR = {16'hFFFF, 74'h0};
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   localparam int LIMIT = 4000;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic pin = 1'b0;
   logic ila = 1'b0;
   logic sdi = 1'b0;
   logic run = 1'b0;
   logic [3:0] mode = 4'h0;
   logic [31:0] rnd = 32'h0000_0028;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic [63:0] lane;
   logic [7:0] lane_en;
   logic enc;
   logic fec;
   logic [15:0] errs;
   logic rd_dph = 1'b0;
   int cyc = 0;
   int failures = 0;
   int check_count = 0;
   jtx_note_t ln_q [$];
   logic [63:0] rd_q [$];

   always #2.5 i_clk = ~i_clk;

   jtx_lane_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_hsel(1'b1),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
      .o_hresp(hresp), .i_shutdown_input(pin), .i_ila_done(ila),
      .i_serdes_init_done(sdi), .i_samp_a({rnd, rnd, rnd[7:0]}),
      .i_samp_b({rnd[7:0], rnd, rnd}), .i_link_octets({rnd, ~rnd}), .o_lane_data(lane),
      .o_lane_en(lane_en), .o_link_encode(enc), .o_fec_en(fec));

   jtx_rx_model rx (.i_clk(i_clk), .i_run(run), .i_mode(mode), .i_lane_data(lane),
      .i_lane_en(lane_en), .o_err(errs));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [31:0] mk(input logic [4:0] f, input logic [3:0] t,
         input logic [3:0] flags);
      return {16'h0, flags, t, 3'h0, f};
   endfunction : mk

   function automatic logic [3:0] nib(input int k, input int x);
      if (x == 15) return 4'h0;
      case (x % 3)
         0: return 4'(15 - k);
         1: return 4'(k);
         default: return 4'(x / 3 + 1);
      endcase
   endfunction : nib

   task automatic check(input logic [89:0] seen, input logic [89:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      if (failures == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   task automatic note(input int d, input logic [89:0] e, input logic [89:0] m);
      int i = ln_q.size();
      while (i > 0 && ln_q[i - 1].due > cyc + d) i--;
      ln_q.insert(i, jtx_note_t'{cyc + d, e, m});
   endtask : note

   // --------------------------------------------------------------
   // Bus cycles
   // --------------------------------------------------------------
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge i_clk);
      while (hready !== 1'b1) @(posedge i_clk);
      htrans <= 2'h0;
      if (w) hwdata <= d;
      @(posedge i_clk);
      while (hready !== 1'b1) @(posedge i_clk);
   endtask : bus

   task automatic wr(input logic [31:0] d);
      bus({24'h0, jtx_pkg::ADDR_CTRL}, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] v);
      rd_q.push_back({m, v});
      bus(a, 1'b0, 32'h0);
   endtask : rd

   // Pattern changes go through a powered-down link so the receiver never sees a torn switch.
   task automatic set(input logic [31:0] c);
      wr(c | (32'h1 << jtx_pkg::CTRL_PD_BIT));
      wr(c);
   endtask : set

   always @(posedge i_clk) begin
      jtx_note_t n;
      logic [63:0] r;
      cyc <= cyc + 1;
      rnd <= lfsr(rnd);
      if (rd_dph && hready) begin
         r = rd_q.pop_front();
         check({57'h0, hresp, hrdata & r[63:32]}, {58'h0, r[31:0]});
      end
      if (hready) rd_dph <= htrans[1] && !hwrite;
      while (ln_q.size() > 0 && ln_q[0].due == cyc) begin
         n = ln_q.pop_front();
         check({errs, lane, lane_en, enc, fec} & n.m, n.e & n.m);
      end
      if (cyc == LIMIT) begin
         failures++;
         print_verdict();
      end
   end

   initial begin
      logic [63:0] v;
      logic [4:0] f;
      int o;
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      rd({24'h0, jtx_pkg::ADDR_CTRL}, ALL, jtx_pkg::CTRL_RESET);
      rd(32'h0000_0100, ALL, 32'h0);
      rd(32'h0000_0008, ALL, 32'h0);
      for (int i = 0; i < 2; i++) begin
         wr(mk(5'h00, 4'h0, {2'h0, i[0], 1'b0}));
         note(2, {80'h0, 8'hFF, 1'b1, i[0]}, M_EN | M_MC);
      end
      for (int i = 0; i < 4; i++) begin
         f = (i < 2) ? 5'(1 + rnd % 7) : 5'(i == 2 ? 0 : 15);
         v[7:0] = (i == 0) ? 8'h0F : (i == 1) ? 8'hF0 : 8'hFF;
         wr(mk(f, 4'h0, {3'h0, i != 0}));
         note(2, {80'h0, v[7:0], 2'h2}, M_EN | M_MC);
      end
      wr(mk(5'h00, 4'h0, 4'h6));
      note(2, 90'h0, M_DAT | M_EN);
      rd({24'h0, jtx_pkg::ADDR_CTRL}, ALL, mk(5'h00, 4'h0, 4'h6));
      wr(mk(5'h00, 4'h0, 4'h2));
      note(2, {80'h0, 8'hFF, 2'h3}, M_EN | M_MC);
      pin <= 1'b1;
      for (int i = 8; i < 12; i++) note(i, 90'h0, M_DAT | M_EN);
      repeat (12) @(posedge i_clk);
      rd({24'h0, jtx_pkg::ADDR_CTRL}, ALL, mk(5'h00, 4'h0, 4'h2));
      pin <= 1'b0;
      note(10, {80'h0, 8'hFF, 2'h3}, M_EN | M_MC);
      repeat (12) @(posedge i_clk);
      for (int t = 1; t <= 6; t++) begin
         f = (t == 6) ? 5'(1 + rnd % 7) : 5'h00;
         set(mk(f, 4'(t), {3'h0, t == 6}));
         mode <= 4'(t);
         repeat (2) @(posedge i_clk);
         run <= 1'b1;
         repeat (40) @(posedge i_clk);
         v[7:0] = (t == 6) ? 8'hF0 : 8'hFF;
         note(1, {16'h0, 64'h0, v[7:0], 2'h0}, M_ERR | M_EN | M_MC);
         run <= 1'b0;
      end
      for (int e = 0; e < 2; e++) begin
         ila <= e[0];
         sdi <= !e[0];
         set(mk(5'h00, 4'h7, {e[0], 3'h0}));
         repeat (6) @(posedge i_clk);
         rd({24'h0, jtx_pkg::ADDR_STAT}, 32'h0000_0800, 32'h0);
         if (e == 0) ila <= 1'b1;
         else sdi <= 1'b1;
         for (int n = 0; n < 40 && lane[7:0] !== 8'h01; n++) @(posedge i_clk);
         for (int j = 0; j < 260; j++) begin
            note(j + 1, {16'h0, {8{8'(j + 2)}}, 10'h2}, M_DAT | M_MC);
         end
         repeat (262) @(posedge i_clk);
      end
      set(mk(5'h00, 4'h8, 4'h0));
      repeat (4) @(posedge i_clk);
      for (int n = 0; n < 40 && lane[7:0] !== 8'h1F; n++) @(posedge i_clk);
      for (int j = 0; j < 24; j++) begin
         o = (j + 2) % 8;
         for (int k = 0; k < 8; k++) v[8*k +: 8] = {nib(k, 2 * o), nib(k, 2 * o + 1)};
         note(j + 1, {16'h0, v, 10'h2}, M_DAT | M_MC);
      end
      repeat (26) @(posedge i_clk);
      set(mk(5'h00, 4'h9, 4'h0));
      note(2, {80'h0, 8'hFF, 2'h2}, M_EN | M_MC);
      for (int n = 0; n < 400 && ln_q.size() > 0; n++) @(posedge i_clk);
      if (ln_q.size() + rd_q.size() != 0) failures++;
      print_verdict();
   end
endmodule : tb

`default_nettype wire
